// file: hw/scs_pkg.sv
// constants and carriers of the clock-stop serial port.
// assumes a single ref_clk domain; configuration arrives as plain ports.
package scs_pkg;

  // --------------------------------------------------------------
  // widths
  // --------------------------------------------------------------
  localparam int WORD_BITS = 8;
  localparam int DIV_BITS  = 8;
  localparam int PIN_COUNT = 6;

  // --------------------------------------------------------------
  // pin positions in the gpio vectors
  // --------------------------------------------------------------
  localparam int PIN_RX_CLK  = 0;
  localparam int PIN_RX_SYNC = 1;
  localparam int PIN_RX_DATA = 2;
  localparam int PIN_TX_CLK  = 3;
  localparam int PIN_TX_SYNC = 4;
  localparam int PIN_TX_DATA = 5;

  // --------------------------------------------------------------
  // codes, counts and reset values
  // --------------------------------------------------------------
  localparam logic [1:0]          STOP_NO_DELAY   = 2'h2;
  localparam logic [1:0]          STOP_HALF_DELAY = 2'h3;
  localparam logic [DIV_BITS-1:0] SLAVE_DIVIDER   = 8'h01;
  localparam logic [DIV_BITS-1:0] PHASE_ONE       = 8'h01;
  localparam logic [WORD_BITS-1:0] WORD_RESET     = 8'h00;
  localparam logic [3:0]          LAST_BIT        = 4'h7;
  localparam logic [8:0]          SETTLE_CYCLES   = 9'h1ff;
  // select pins idle high, so a slave sees no select after reset
  localparam logic [4:0]          SYNC_IDLE       = 5'h12;

  typedef struct packed {
    logic [1:0]          clock_stop_select;
    logic                tx_clock_polarity;
    logic                tx_sync_polarity;
    logic                rx_sync_polarity;
    logic                tx_clock_direction;
    logic                tx_sync_direction;
    logic                rx_clock_direction;
    logic                rx_sync_direction;
    logic                generator_source_select;
    logic [DIV_BITS-1:0] sample_rate_divider;
  } scs_cfg_type;

  typedef enum logic [1:0] {
    SCS_IDLE  = 2'b00,
    SCS_LEAD  = 2'b01,
    SCS_SHIFT = 2'b10,
    SCS_TAIL  = 2'b11
  } scs_state_type;

endpackage

// file: hw/scs_clkgen.sv
// shift clock generator running from the cpu output clock.
// assumes ref_clk is the cpu output clock, one cycle = two half-cycles.
`timescale 1ns/1ps
module scs_clkgen (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst_b,
  // control
  input  wire logic                         run,
  input  wire logic [scs_pkg::DIV_BITS-1:0] divider,
  // generated clock
  output logic                              level,
  output logic                              rise,
  output logic                              fall
);

  // --------------------------------------------------------------
  // phase lengths
  // --------------------------------------------------------------
  logic [7:0] cnt_reg;
  logic       level_reg;
  logic       rise_reg;
  logic       fall_reg;

  wire [8:0] div_up    = {1'b0, divider} + 9'h001;
  wire       div_zero  = divider == 8'h00;
  wire [7:0] half_up   = div_up[8:1];
  wire [7:0] half_dn   = {1'b0, divider[7:1]};
  // a zero divider cannot give half a cycle; both phases take one
  wire [7:0] low_len   = div_zero ? scs_pkg::PHASE_ONE :
                         (divider[0] ? half_up : half_dn); // R2
  wire [7:0] high_len  = div_zero ? scs_pkg::PHASE_ONE :
                         (divider[0] ? half_up :
                          half_dn + scs_pkg::PHASE_ONE); // R3
  wire [7:0] phase_len = level_reg ? high_len : low_len;
  wire       phase_end = cnt_reg == phase_len - scs_pkg::PHASE_ONE;

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt_reg   <= 8'h00;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
    end
    // halted generator parks low, ready to restart from a low phase
    else if (!run)
    begin
      cnt_reg   <= 8'h00;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
    end
    else
    begin
      cnt_reg   <= phase_end ? 8'h00 : cnt_reg + 8'h01; // R1
      level_reg <= level_reg ^ phase_end;
      rise_reg  <= phase_end & ~level_reg;
      fall_reg  <= phase_end & level_reg;
    end

  assign level = level_reg;
  assign rise  = rise_reg;
  assign fall  = fall_reg;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  logic       prev_reg;
  logic [7:0] track_reg;
  logic [8:0] per_reg;
  logic [8:0] settle_reg;
  logic [7:0] div_d_reg;

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      prev_reg   <= 1'b0;
      track_reg  <= 8'h00;
      per_reg    <= 9'h000;
      settle_reg <= 9'h000;
      div_d_reg  <= 8'h00;
    end
    else
    begin
      prev_reg   <= level_reg;
      track_reg  <= (level_reg ^ prev_reg) ? 8'h01 : track_reg + 8'h01;
      per_reg    <= rise_reg ? 9'h001 : per_reg + 9'h001;
      div_d_reg  <= divider;
      settle_reg <= (!run || divider != div_d_reg) ? 9'h000 :
                    (settle_reg == scs_pkg::SETTLE_CYCLES ? settle_reg
                     : settle_reg + 9'h001);
    end

  wire settled = settle_reg == scs_pkg::SETTLE_CYCLES;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_low_width: assert property (rise_reg && settled |->
    track_reg == low_len) // R2
    else $error("shift clock low phase has wrong length");
  a_high_width: assert property (fall_reg && settled |->
    track_reg == high_len) // R3
    else $error("shift clock high phase has wrong length");
  a_clock_period: assert property (rise_reg && settled && !div_zero |->
    per_reg == div_up) // R1
    else $error("shift clock period differs from divider plus one");

endmodule

// file: hw/scs_buf2.sv
// two-entry word buffer with valid and ready on both sides.
// assumes one clock; read data always come from a register.
`timescale 1ns/1ps
module scs_buf2 #(
  parameter int WIDTH = scs_pkg::WORD_BITS
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] head_reg;
  logic [WIDTH-1:0] tail_reg;
  logic [1:0]       fill_reg;
  logic             valid_reg;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = fill_reg != 2'h2;
  // valid kept in its own flop so it leaves the port undecoded
  assign out_valid = valid_reg;
  assign out_data  = head_reg;

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      head_reg <= '0;
      tail_reg <= '0;
      fill_reg <= 2'h0;
      valid_reg <= 1'b0;
    end
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          if (fill_reg == 2'h0)
            head_reg <= in_data;
          else
            tail_reg <= in_data;
          fill_reg <= fill_reg + 2'h1;
          valid_reg <= 1'b1;
        end
        2'b01:
        begin
          head_reg <= tail_reg;
          fill_reg <= fill_reg - 2'h1;
          valid_reg <= fill_reg == 2'h2;
        end
        // one word held: it leaves while the new one takes its place
        2'b11:
          head_reg <= (fill_reg == 2'h1) ? in_data : tail_reg;
        default:
          fill_reg <= fill_reg;
      endcase
    end

endmodule

// file: hw/scs_spi.sv
// clock-stop serial port: spi master or slave, plus pins as gpio.
// assumes ref_clk is the cpu output clock and config holds steady
// while a word is on the wire.
//
// Operation
// R1 - shift clock period is divider plus one; a zero divider gives two cycles
// R2 - low phase: half, or divider/2 when even
// R3 - high phase: half, or divider/2+1 when even
// R4 - slave use: cpu source, divider set to 1
// R5 - master drives select inverted, active low
// R6 - slave inverts received active-low selects
// R7 - master: tx clock/sync driven, rx ones inputs
// R8 - slave: all four clock/sync pins inputs
// R9 - master lowers select before first rising edge
// R10 - code 10b: launch after rising edges
// R11 - code 11b: launch on falling, clock after period
// R12 - receive data sampled on falling edges
// R13 - slave releases data when select returns high
// R14 - gpio inputs sampled on cpu clock rising edge
// R15 - gpio outputs updated after cpu clock edge
// R16 - inverted polarity swaps the reference edge
`timescale 1ns/1ps
module scs_spi (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  // configuration
  input  wire scs_pkg::scs_cfg_type          cfg,
  input  wire logic [scs_pkg::PIN_COUNT-1:0] gpio_enable,
  input  wire logic [scs_pkg::PIN_COUNT-1:0] gpio_out_value,
  output logic [scs_pkg::PIN_COUNT-2:0]      gpio_in_value,
  // transmit words
  input  wire logic                          tx_valid,
  input  wire logic [scs_pkg::WORD_BITS-1:0] tx_word,
  output logic                               tx_ready,
  // receive words
  output logic                               rx_valid,
  output logic [scs_pkg::WORD_BITS-1:0]      rx_word,
  input  wire logic                          rx_ready,
  // status
  output logic                               busy,
  output logic                               overrun,
  // receive pins
  input  wire logic                          rx_shift_clock_pin_i,
  output logic                               rx_shift_clock_pin_o,
  output logic                               rx_shift_clock_pin_oe,
  input  wire logic                          rx_frame_sync_pin_i,
  output logic                               rx_frame_sync_pin_o,
  output logic                               rx_frame_sync_pin_oe,
  input  wire logic                          rx_data_pin_i,
  // transmit pins
  input  wire logic                          tx_shift_clock_pin_i,
  output logic                               tx_shift_clock_pin_o,
  output logic                               tx_shift_clock_pin_oe,
  input  wire logic                          tx_frame_sync_pin_i,
  output logic                               tx_frame_sync_pin_o,
  output logic                               tx_frame_sync_pin_oe,
  output logic                               tx_data_pin_o,
  output logic                               tx_data_pin_oe
);

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic       clk_d_reg;

  wire [4:0] pins_in = {tx_frame_sync_pin_i, tx_shift_clock_pin_i,
                        rx_data_pin_i, rx_frame_sync_pin_i,
                        rx_shift_clock_pin_i};

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      sync1_reg <= scs_pkg::SYNC_IDLE;
      sync2_reg <= scs_pkg::SYNC_IDLE;
      clk_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      clk_d_reg <= sync2_reg[scs_pkg::PIN_TX_CLK];
    end

  // --------------------------------------------------------------
  // mode decode and edges
  // --------------------------------------------------------------
  logic g_level;
  logic g_rise;
  logic g_fall;

  wire master = cfg.tx_clock_direction & cfg.tx_sync_direction; // R7
  wire late   = cfg.clock_stop_select == scs_pkg::STOP_HALF_DELAY;
  wire spi_on = late |
                (cfg.clock_stop_select == scs_pkg::STOP_NO_DELAY);
  wire pol    = cfg.tx_clock_polarity;

  // generator only runs from the cpu clock source
  scs_clkgen u_clkgen (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .run     (cfg.generator_source_select),
    .divider (cfg.sample_rate_divider),
    .level   (g_level),
    .rise    (g_rise),
    .fall    (g_fall)
  );

  wire s_clk    = sync2_reg[scs_pkg::PIN_TX_CLK];
  wire s_rise   = s_clk & ~clk_d_reg;
  wire s_fall   = ~s_clk & clk_d_reg;
  wire edge_a   = master ? g_rise : s_rise;
  wire edge_b   = master ? g_fall : s_fall;
  wire pin_rise = pol ? edge_b : edge_a; // R16
  wire pin_fall = pol ? edge_a : edge_b; // R16
  // slave selects arrive active low and are inverted here
  wire sel_in  = sync2_reg[scs_pkg::PIN_TX_SYNC] ^
                 cfg.tx_sync_polarity; // R6
  wire rsel_in = sync2_reg[scs_pkg::PIN_RX_SYNC] ^
                 cfg.rx_sync_polarity; // R6
  wire rx_bit  = sync2_reg[scs_pkg::PIN_RX_DATA];
  wire start_edge = late ? pin_rise : pin_fall;

  // --------------------------------------------------------------
  // word path
  // --------------------------------------------------------------
  scs_pkg::scs_state_type state_reg;
  scs_pkg::scs_state_type state_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] rsh_reg;
  logic [7:0] rsh_next;
  logic [7:0] hold_reg;
  logic [7:0] push_word;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       sel_reg;
  logic       sel_next;
  logic       clk_en_reg;
  logic       clk_en_next;
  logic       doe_reg;
  logic       doe_next;
  logic       hold_valid_reg;
  logic       tx_ready_reg;
  logic       take_hold;
  logic       buf_push;
  logic       buf_ready;
  logic       overrun_reg;
  logic       busy_reg;

  wire last   = cnt_reg == scs_pkg::LAST_BIT;
  wire sample = pin_fall & (master | rsel_in); // R12
  wire accept = tx_valid & tx_ready_reg;
  wire hold_valid_next = accept | (hold_valid_reg & ~take_hold);

  always_comb
  begin
    state_next  = state_reg;
    sel_next    = sel_reg;
    clk_en_next = clk_en_reg;
    doe_next    = doe_reg;
    shift_next  = shift_reg;
    rsh_next    = rsh_reg;
    cnt_next    = cnt_reg;
    take_hold   = 1'b0;
    buf_push    = 1'b0;
    push_word   = rsh_reg;
    case (state_reg)
      scs_pkg::SCS_IDLE:
      begin
        // a full receive buffer holds off the next master word
        if (spi_on && master && hold_valid_reg && buf_ready &&
            start_edge)
        begin
          sel_next    = 1'b1; // R9
          shift_next  = hold_reg;
          take_hold   = 1'b1;
          cnt_next    = 4'h0;
          clk_en_next = !late; // R10
          state_next  = late ? scs_pkg::SCS_LEAD : scs_pkg::SCS_SHIFT;
        end
        else if (spi_on && !master && sel_in)
        begin
          shift_next = hold_valid_reg ? hold_reg : scs_pkg::WORD_RESET;
          take_hold  = hold_valid_reg;
          doe_next   = 1'b1;
          cnt_next   = 4'h0;
          state_next = scs_pkg::SCS_SHIFT;
        end
      end
      scs_pkg::SCS_LEAD:
      begin
        if (pin_fall)
          doe_next = 1'b1; // R11
        if (pin_rise)
        begin
          clk_en_next = 1'b1; // R11
          state_next  = scs_pkg::SCS_SHIFT;
        end
      end
      scs_pkg::SCS_SHIFT:
      begin
        if (!master && !sel_in)
        begin
          doe_next   = 1'b0; // R13
          state_next = scs_pkg::SCS_IDLE;
        end
        else
        begin
          if (pin_rise && !late)
          begin
            if (cnt_reg != 4'h0)
              shift_next = {shift_reg[6:0], 1'b0}; // R10
            doe_next = 1'b1;
          end
          if (sample)
          begin
            rsh_next = {rsh_reg[6:0], rx_bit}; // R12
            cnt_next = cnt_reg + 4'h1;
            if (late)
              shift_next = {shift_reg[6:0], 1'b0}; // R11
            if (last)
            begin
              clk_en_next = 1'b0;
              state_next  = scs_pkg::SCS_TAIL;
              buf_push    = !master;
              push_word   = {rsh_reg[6:0], rx_bit};
            end
          end
        end
      end
      scs_pkg::SCS_TAIL:
      begin
        if (master && start_edge)
        begin
          sel_next   = 1'b0;
          doe_next   = 1'b0;
          buf_push   = 1'b1;
          state_next = scs_pkg::SCS_IDLE;
        end
        else if (!master && !sel_in)
        begin
          doe_next   = 1'b0; // R13
          state_next = scs_pkg::SCS_IDLE;
        end
      end
      default:
        state_next = scs_pkg::SCS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      state_reg      <= scs_pkg::SCS_IDLE;
      shift_reg      <= scs_pkg::WORD_RESET;
      rsh_reg        <= scs_pkg::WORD_RESET;
      hold_reg       <= scs_pkg::WORD_RESET;
      cnt_reg        <= 4'h0;
      sel_reg        <= 1'b0;
      clk_en_reg     <= 1'b0;
      doe_reg        <= 1'b0;
      hold_valid_reg <= 1'b0;
      tx_ready_reg   <= 1'b0;
      overrun_reg    <= 1'b0;
      busy_reg       <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      shift_reg      <= shift_next;
      rsh_reg        <= rsh_next;
      hold_reg       <= accept ? tx_word : hold_reg;
      cnt_reg        <= cnt_next;
      sel_reg        <= sel_next;
      clk_en_reg     <= clk_en_next;
      doe_reg        <= doe_next;
      hold_valid_reg <= hold_valid_next;
      tx_ready_reg   <= !hold_valid_next;
      overrun_reg    <= buf_push & !buf_ready;
      busy_reg       <= state_next != scs_pkg::SCS_IDLE;
    end

  scs_buf2 #(
    .WIDTH (scs_pkg::WORD_BITS)
  ) u_rxbuf (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .in_valid  (buf_push),
    .in_data   (push_word),
    .in_ready  (buf_ready),
    .out_valid (rx_valid),
    .out_data  (rx_word),
    .out_ready (rx_ready)
  );

  // --------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------
  // built from next state so every pin trails the generator by one
  logic [5:0] pin_o_reg;
  logic [5:0] pin_oe_reg;
  logic [4:0] gpio_in_reg;

  wire clk_drive = clk_en_next ? (g_level ^ pol) : pol; // R16
  wire [5:0] spi_o = {shift_next[7],
                      sel_next ^ cfg.tx_sync_polarity, // R5
                      clk_drive, 1'b0,
                      sel_next ^ cfg.rx_sync_polarity, clk_drive};
  wire [5:0] pin_oe_next = {gpio_enable[5] | doe_next,
                            cfg.tx_sync_direction,
                            cfg.tx_clock_direction, 1'b0,
                            cfg.rx_sync_direction,
                            cfg.rx_clock_direction}; // R8

  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      pin_o_reg   <= 6'h00;
      pin_oe_reg  <= 6'h00;
      gpio_in_reg <= 5'h00;
    end
    else
    begin
      pin_o_reg   <= (gpio_enable & gpio_out_value) |
                     (~gpio_enable & spi_o); // R15
      pin_oe_reg  <= pin_oe_next; // R7
      gpio_in_reg <= sync2_reg; // R14
    end

  assign rx_shift_clock_pin_o  = pin_o_reg[scs_pkg::PIN_RX_CLK];
  assign rx_shift_clock_pin_oe = pin_oe_reg[scs_pkg::PIN_RX_CLK];
  assign rx_frame_sync_pin_o   = pin_o_reg[scs_pkg::PIN_RX_SYNC];
  assign rx_frame_sync_pin_oe  = pin_oe_reg[scs_pkg::PIN_RX_SYNC];
  assign tx_shift_clock_pin_o  = pin_o_reg[scs_pkg::PIN_TX_CLK];
  assign tx_shift_clock_pin_oe = pin_oe_reg[scs_pkg::PIN_TX_CLK];
  assign tx_frame_sync_pin_o   = pin_o_reg[scs_pkg::PIN_TX_SYNC];
  assign tx_frame_sync_pin_oe  = pin_oe_reg[scs_pkg::PIN_TX_SYNC];
  assign tx_data_pin_o         = pin_o_reg[scs_pkg::PIN_TX_DATA];
  assign tx_data_pin_oe        = pin_oe_reg[scs_pkg::PIN_TX_DATA];
  assign gpio_in_value         = gpio_in_reg;
  assign tx_ready              = tx_ready_reg;
  assign overrun               = overrun_reg;
  assign busy                  = busy_reg;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_master_start;
    master && spi_on && state_reg == scs_pkg::SCS_IDLE &&
    state_next != scs_pkg::SCS_IDLE;
  endsequence

  a_select_active_low: assert property (sel_next && master && // R5
    cfg.tx_sync_polarity && !gpio_enable[4] |=> !tx_frame_sync_pin_o)
    else $error("master select not driven low");
  a_master_pin_dirs: assert property (master && // R7
    !cfg.rx_clock_direction && !cfg.rx_sync_direction |=>
    tx_shift_clock_pin_oe && tx_frame_sync_pin_oe &&
    !rx_shift_clock_pin_oe && !rx_frame_sync_pin_oe)
    else $error("master pin directions wrong");
  a_slave_pin_dirs: assert property (!cfg.tx_clock_direction && // R8
    !cfg.tx_sync_direction && !cfg.rx_clock_direction &&
    !cfg.rx_sync_direction |=> !tx_shift_clock_pin_oe &&
    !tx_frame_sync_pin_oe && !rx_shift_clock_pin_oe &&
    !rx_frame_sync_pin_oe)
    else $error("slave clock or select pin driven");
  a_select_before_clk: assert property (s_master_start ##0 // R9
    (!late && !pol && cfg.tx_sync_polarity && gpio_enable == 6'h00)
    |=> !tx_shift_clock_pin_o && !tx_frame_sync_pin_o)
    else $error("select not low ahead of first rising edge");
  a_late_lead_phase: assert property (s_master_start ##0 // R11
    (late && !gpio_enable[5]) |=>
    state_reg == scs_pkg::SCS_LEAD && !clk_en_reg && !tx_data_pin_oe)
    else $error("code 11b clock or data started too early");
  a_fall_sample: assert property (state_reg == // R12
    scs_pkg::SCS_SHIFT && sample && (master || sel_in) |=>
    cnt_reg == $past(cnt_reg) + 4'h1 && rsh_reg[0] == $past(rx_bit))
    else $error("receive bit not taken on falling edge");
  a_slave_release: assert property (!master && spi_on && // R13
    state_reg != scs_pkg::SCS_IDLE && !sel_in && !gpio_enable[5]
    |=> !tx_data_pin_oe && state_reg == scs_pkg::SCS_IDLE)
    else $error("slave data pin not released");
  a_gpio_sample: assert property ($past(rst_b, 3) |-> // R14
    gpio_in_value == $past(pins_in, 3))
    else $error("gpio input not sampled three edges late");
  a_gpio_drive: assert property (gpio_enable[5] |=> // R15
    tx_data_pin_oe && tx_data_pin_o == $past(gpio_out_value[5]))
    else $error("gpio data output not updated");

endmodule

// file: tb/scs_peer.sv
// spi slave model facing the port as master.
// assumes pin clock idles low and select is active low.
`timescale 1ns/1ps
module scs_peer (
  // pins
  input  wire logic  sclk,
  input  wire logic  sel_b,
  input  wire logic  late,
  input  wire logic  mosi,
  output logic       miso,
  // captured word
  output logic [7:0] got,
  output int         cnt
);
  logic [7:0] sh;
  logic [7:0] rep = 8'h5a;
  int         n;
  initial miso = 1'b0;
  initial cnt = 0;
  always @(negedge sel_b)
  begin
    n = 0;
    miso = rep[7];
  end
  // released line shows the inverse, never the held bit
  always @(posedge sel_b) miso = ~miso;
  always @(sclk)
    if (!sel_b && sclk == late)
    begin
      sh = {sh[6:0], mosi};
      n++;
      if (n == 8)
      begin
        got = sh;
        rep = ~sh;
        cnt++;
      end
    end
    else if (!sel_b && n > 0 && n < 8)
      miso = rep[7-n];
endmodule

// file: tb/test_serial_port_spi_clock_stop.sv
// self-checking bench: port as spi master against a slave model.
// assumes the design package is compiled first.
`timescale 1ns/1ps
module test_serial_port_spi_clock_stop;
  logic                ref_clk, rst_b, tx_valid, tx_ready, rx_valid;
  logic                rx_ready, rck_i, rck_o, rck_oe, rfs_oe, tck;
  logic                tfs, tfs_oe, txd, miso, pt, busy, ovr, rfs_o;
  logic                tck_oe, txd_oe;
  logic [7:0]          tx_word, rx_word, got, rep, txq[$], rxq[$];
  logic [5:0]          gen, gout;
  logic [4:0]          gin;
  logic [31:0]         seed = 32'h9cadca97;
  scs_pkg::scs_cfg_type cfg;
  int n_errors = 0, n_compared = 0, cyc = 0, run = 0, nr = 0;
  int cnt, i, k, d;
  scs_spi uut (.ref_clk(ref_clk), .rst_b(rst_b), .cfg(cfg),
    .gpio_enable(gen), .gpio_out_value(gout), .gpio_in_value(gin),
    .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready),
    .busy(busy), .overrun(ovr), .rx_shift_clock_pin_i(rck_i),
    .rx_shift_clock_pin_o(rck_o), .rx_shift_clock_pin_oe(rck_oe),
    .rx_frame_sync_pin_i(1'b1), .rx_frame_sync_pin_o(rfs_o),
    .rx_frame_sync_pin_oe(rfs_oe), .rx_data_pin_i(miso),
    .tx_shift_clock_pin_i(tck), .tx_shift_clock_pin_o(tck),
    .tx_shift_clock_pin_oe(tck_oe), .tx_frame_sync_pin_i(tfs),
    .tx_frame_sync_pin_o(tfs), .tx_frame_sync_pin_oe(tfs_oe),
    .tx_data_pin_o(txd), .tx_data_pin_oe(txd_oe));
  scs_peer peer (.sclk(tck), .sel_b(tfs), .mosi(txd), .miso(miso),
    .late(cfg.clock_stop_select[0]), .got(got), .cnt(cnt));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // valid stays up between back-to-back words
  task automatic send(input logic [7:0] w);
    tx_valid = 1'b1;
    tx_word = w;
    txq.push_back(w);
    rxq.push_back(rep);
    rep = ~w;
    while (!tx_ready) @(posedge ref_clk) #1;
    @(posedge ref_clk) #1;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    rx_ready <= #1 1'(rnd());
    if (cyc == 30000)
    begin
      n_errors++;
      finish_test();
    end
  end
  // --------------------------------------------------------------
  // result watchers
  // --------------------------------------------------------------
  always @(cnt) check(got, txq.pop_front());
  always @(posedge ref_clk)
    if (rx_valid && rx_ready) check(rx_word, rxq.pop_front());
  // while select is driven: busy follows select, no overrun, rx select mirrors tx select
  always @(posedge ref_clk)
    if (tfs_oe) check(8'({busy, ovr, rfs_o}), 8'({!tfs, 1'b0, tfs}));
  // reset holds select low, so no widths until the pins come up
  always @(posedge ref_clk)
    if (tfs || !tfs_oe)
    begin
      nr = 0;
      pt = tck;
      if (!gen[5]) check(8'(txd_oe), 8'h00);
    end
    else if (tck == pt) run++;
    else
    begin
      if (!tck) check(8'(run), 8'(d / 2 + 1));
      else if (nr++ > 0)
        check(8'(run), 8'((d + 1) / 2));
      run = 1;
      pt = tck;
    end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    {tx_valid, tx_word, gen, gout, rck_i, rst_b} = '0;
    rep = 8'h5a;
    d = 7;
    cfg = '0;
    cfg.tx_sync_polarity = 1'b1;
    cfg.rx_sync_polarity = 1'b1;
    cfg.tx_clock_direction = 1'b1;
    cfg.tx_sync_direction = 1'b1;
    cfg.generator_source_select = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      d = 7 + i / 2;
      cfg.clock_stop_select = {1'b1, i[0]};
      cfg.sample_rate_divider = 8'(d);
      repeat (2) @(posedge ref_clk) #1;
      check(8'({rck_oe, rfs_oe, tck_oe, tfs_oe}), 8'h03);
      for (k = 0; k < 3; k++) send(8'(rnd()));
      tx_valid = 1'b0;
      while (txq.size() || rxq.size()) @(posedge ref_clk) #1;
    end
    gen = 6'h21;
    gout = 6'(rnd()) | 6'h01;
    rck_i = ~gin[0];
    repeat (4) @(posedge ref_clk) #1;
    check(8'({rck_o, txd}), 8'({gout[0], gout[5]}));
    check(8'(gin[0]), 8'(rck_i));
    finish_test();
  end
endmodule
